/* hdl/psm_pkg.sv */
/*
 Constants, field layouts and carrier types of the strap and pin-function mux.
 Assumes a 40 MHz core clock and a link clock from the MAC side.
*/
package psm_pkg;
  localparam int CLK_MHZ   = 40;
  localparam int STRAP_NS  = 1000;
  localparam int STRAP_CYC = (STRAP_NS * CLK_MHZ + 999) / 1000;
  localparam int BLINK_MS  = 100;
  localparam int BLINK_DFLT = BLINK_MS * CLK_MHZ * 1000;

  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_ADV   = 8'h04;
  localparam logic [7:0] REG_PCTL  = 8'h08;
  localparam logic [7:0] REG_STRAP = 8'h0c;

  localparam int CTRL_SPEED = 13;
  localparam int CTRL_ANEG  = 12;
  localparam int CTRL_ISO   = 10;
  localparam int CTRL_DUP   = 8;
  localparam int ADV_LO     = 5;
  localparam int PCTL_LED   = 14;
  localparam int PCTL_POL   = 9;

  localparam logic [3:0]  ADV_CAP_100 = 4'hf;
  localparam logic [3:0]  ADV_CAP_10  = 4'h3;
  localparam logic [15:0] PCTL_RST    = 16'h0000;
  localparam logic [2:0]  IFACE_MII   = 3'h0;
  localparam logic [2:0]  IFACE_RMII  = 3'h1;
  localparam logic [2:0]  IFACE_PRE   = 3'h4;
  localparam logic [1:0]  LED_LINKACT = 2'h0;
  localparam logic [1:0]  LED_LINK    = 2'h1;

  typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_MII_PRE, MODE_RSVD} psm_mode_t;

  // One bit per dual-purpose pin, named by its strap meaning
  typedef struct packed {
    logic       autoneg;
    logic       speed;
    logic       duplex;
    logic       detach;
    logic [2:0] iface;
    logic [2:0] addr;
  } psm_strap_t;

  localparam psm_strap_t STRAP_DFLT = '{autoneg: 1'b1, speed: 1'b1, duplex: 1'b1,
                                        detach: 1'b0, iface: 3'h0, addr: 3'h1};

  typedef struct packed {
    logic [3:0] rxd;
    logic       dv;
    logic       er;
    logic       col;
    logic       crs;
  } psm_rxpin_t;
endpackage : psm_pkg

/* hdl/psm_sync.sv */
/*
 Two-flop level synchroniser, any width.
 Assumes each bit is a slow level or a static value.
*/
`timescale 1ns/1ps
module psm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("psm_sync width must be positive");
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule : psm_sync

/* hdl/psm_led.sv */
/*
 Indicator drivers for the two LED pins, with activity blink.
 Assumes link, speed and activity levels already in the core domain.
*/
`timescale 1ns/1ps
module psm_led
  import psm_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_DFLT
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_link,
  input  wire logic       i_speed100,
  input  wire logic       i_act,
  output logic            o_first_indicator_out,
  output logic            o_second_indicator_out
);
  localparam int CW = $clog2(BLINK_CYC + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          blink_q, blink_d;
  logic          pend_q, pend_d;
  logic          first_indicator_out_q, first_indicator_out_d;
  logic          second_indicator_out_q, second_indicator_out_d;

  initial begin
    if (BLINK_CYC < 2) $error("BLINK_CYC too small");
  end

  always_comb begin
    cnt_d   = cnt_q + CW'(1);
    blink_d = blink_q;
    // Activity seen in the same cycle as the wrap is kept
    pend_d  = pend_q | i_act;
    if (cnt_q == CW'(BLINK_CYC - 1)) begin
      cnt_d   = '0;
      blink_d = pend_q & ~blink_q;
      pend_d  = i_act;
    end
    unique case (i_mode)
      LED_LINKACT: first_indicator_out_d = ~i_link | blink_q;
      LED_LINK:    first_indicator_out_d = ~i_link;
      default:     first_indicator_out_d = 1'b1;
    endcase
    unique case (i_mode)
      LED_LINKACT: second_indicator_out_d = ~i_speed100;
      LED_LINK:    second_indicator_out_d = ~blink_q;
      default:     second_indicator_out_d = 1'b1;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q   <= '0;
      blink_q <= 1'b0;
      pend_q  <= 1'b0;
      first_indicator_out_q  <= 1'b1;
      second_indicator_out_q  <= 1'b1;
    end else begin
      cnt_q   <= cnt_d;
      blink_q <= blink_d;
      pend_q  <= pend_d;
      first_indicator_out_q  <= first_indicator_out_d;
      second_indicator_out_q  <= second_indicator_out_d;
    end
  end

  assign o_first_indicator_out = first_indicator_out_q;
  assign o_second_indicator_out = second_indicator_out_q;

  link_only_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_mode == LED_LINK |=> o_first_indicator_out == !$past(i_link))
    else $error("first indicator not following link");
  speed_led_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_mode == LED_LINKACT |=> o_second_indicator_out == !$past(i_speed100))
    else $error("second indicator not showing speed");
endmodule : psm_led

/* hdl/psm_top.sv */
/*
 Strap capture and MII/RMII pin-function mux with register port.
 Assumes the MAC drives transmit pins on the link clock and the
 PHY core presents receive symbols on the same link clock.
*/
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module psm_top
  import psm_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_DFLT
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_link_clk,
  input  wire logic        i_chip_rst_n,
  input  wire psm_strap_t  i_pin_in,
  output psm_strap_t       o_pin_out,
  output psm_strap_t       o_pin_oe,
  input  wire logic        i_transmit_enable_in,
  input  wire logic [3:0]  i_txd,
  input  wire psm_rxpin_t  i_phy_rx,
  output logic [3:0]       o_tx_dat,
  output logic             o_tx_vld,
  input  wire logic        i_link_up,
  input  wire logic        i_irq_cond,
  output logic             o_irq_out,
  input  wire logic        i_mdc,
  input  wire logic        i_mdio_in,
  output logic             o_mdio_out,
  output logic             o_mdio_oe,
  input  wire logic        i_mgmt_dout,
  input  wire logic        i_mgmt_doe,
  output logic             o_mgmt_din,
  output logic             o_mgmt_din_vld,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic [15:0]      o_reg_rdata,
  output logic [4:0]       o_station_number,
  output psm_mode_t        o_mode
);
  localparam int SW = $clog2(STRAP_CYC + 1);

  typedef enum logic {ST_STRAP, ST_RUN} psm_state_t;

  // Core-domain state
  psm_state_t    state_q, state_d;
  logic [SW-1:0] cnt_q, cnt_d;
  psm_strap_t    strap_q, strap_d;
  logic [15:0]   ctrl_q, ctrl_d;
  logic [3:0]    adv_q, adv_d;
  logic [15:0]   pctl_q, pctl_d;
  logic [15:0]   rdata_q, rdata_d;
  logic          irq_q, irq_d;
  logic          mdc_q, mdc_d;
  logic          mdo_q, mdo_d;
  logic          mdoe_q, mdoe_d;
  logic          din_q, din_d;
  logic          dinv_q, dinv_d;
  logic          latch;
  psm_mode_t     mode;
  logic          run;

  // Synchronised inputs
  psm_strap_t    pin_s;
  logic          rst_n_s;
  logic          mdc_s;
  logic          mdio_s;
  logic          act_s;

  // Link-domain state, plus the core-domain LED outputs
  psm_rxpin_t    rxp_q, rxp_d;
  logic [3:0]    tx_q, tx_d;
  logic          txv_q, txv_d;
  logic          act_q, act_d;
  logic          run_l;
  logic          rmii_l;
  logic          first_indicator_out;
  logic          second_indicator_out;

  initial begin
    if (BLINK_CYC < 2) $error("BLINK_CYC too small");
  end

  psm_sync #(.W(10)) u_pin_sync (
    .i_clk (i_core_clk),
    .i_rst (i_sys_rst),
    .i_d   (i_pin_in),
    .o_q   (pin_s)
  );

  psm_sync #(.W(4)) u_core_sync (
    .i_clk (i_core_clk),
    .i_rst (i_sys_rst),
    .i_d   ({i_chip_rst_n, i_mdc, i_mdio_in, act_q}),
    .o_q   ({rst_n_s, mdc_s, mdio_s, act_s})
  );

  psm_sync #(.W(2)) u_link_sync (
    .i_clk (i_link_clk),
    .i_rst (i_sys_rst),
    .i_d   ({run, mode == MODE_RMII}),
    .o_q   ({run_l, rmii_l})
  );

  psm_led #(.BLINK_CYC(BLINK_CYC)) u_led (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_mode     (pctl_q[PCTL_LED+:2]),
    .i_link     (i_link_up),
    .i_speed100 (ctrl_q[CTRL_SPEED]),
    .i_act      (act_s),
    .o_first_indicator_out     (first_indicator_out),
    .o_second_indicator_out     (second_indicator_out)
  );

  assign run = (state_q == ST_RUN);

  always_comb begin
    unique case (strap_q.iface)
      IFACE_MII:  mode = MODE_MII;
      IFACE_RMII: mode = MODE_RMII;
      IFACE_PRE:  mode = MODE_MII_PRE;
      default:    mode = MODE_RSVD;
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    strap_d = strap_q;
    ctrl_d  = ctrl_q;
    adv_d   = adv_q;
    pctl_d  = pctl_q;
    latch   = 1'b0;
    unique case (state_q)
      ST_STRAP: begin
        if (!rst_n_s) begin
          cnt_d = '0;
        end else if (cnt_q == SW'(STRAP_CYC - 1)) begin
          state_d = ST_RUN;
          latch   = 1'b1;
        end else begin
          cnt_d = cnt_q + SW'(1);
        end
      end
      ST_RUN: begin
        if (!rst_n_s) begin
          state_d = ST_STRAP;
          cnt_d   = '0;
        end
      end
    endcase
    if (run && i_reg_wr) begin
      unique case (i_reg_addr)
        REG_CTRL: ctrl_d = i_reg_wdata;
        REG_ADV:  adv_d  = i_reg_wdata[ADV_LO+:4];
        REG_PCTL: pctl_d = i_reg_wdata;
        default:  ;
      endcase
    end
    if (latch) begin
      strap_d = pin_s;
      ctrl_d[CTRL_ISO]   = pin_s.detach;
      ctrl_d[CTRL_SPEED] = pin_s.speed;
      adv_d              = pin_s.speed ? ADV_CAP_100 : ADV_CAP_10;
      ctrl_d[CTRL_DUP]   = ~pin_s.duplex;
      ctrl_d[CTRL_ANEG]  = pin_s.autoneg;
    end
    rdata_d = '0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_CTRL:  rdata_d = ctrl_q;
        REG_ADV:   rdata_d = 16'(adv_q) << ADV_LO;
        REG_PCTL:  rdata_d = pctl_q;
        REG_STRAP: rdata_d = {8'h00, strap_q.iface, o_station_number};
        default:   rdata_d = '0;
      endcase
    end
    irq_d = pctl_q[PCTL_POL] ? i_irq_cond : ~i_irq_cond;
    // sample on rise, drive on fall
    mdc_d  = mdc_s;
    din_d  = din_q;
    dinv_d = 1'b0;
    mdo_d  = mdo_q;
    mdoe_d = mdoe_q;
    if (mdc_s && !mdc_q) begin
      din_d  = mdio_s;
      dinv_d = 1'b1;
    end
    if (!mdc_s && mdc_q) begin
      mdo_d  = i_mgmt_dout;
      mdoe_d = i_mgmt_doe & run;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_STRAP;
      cnt_q   <= '0;
      strap_q <= STRAP_DFLT;
      ctrl_q  <= '0;
      adv_q   <= ADV_CAP_100;
      pctl_q  <= PCTL_RST;
      rdata_q <= '0;
      irq_q   <= 1'b1;
      mdc_q   <= 1'b0;
      mdo_q   <= 1'b0;
      mdoe_q  <= 1'b0;
      din_q   <= 1'b0;
      dinv_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      strap_q <= strap_d;
      ctrl_q  <= ctrl_d;
      adv_q   <= adv_d;
      pctl_q  <= pctl_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      mdc_q   <= mdc_d;
      mdo_q   <= mdo_d;
      mdoe_q  <= mdoe_d;
      din_q   <= din_d;
      dinv_q  <= dinv_d;
    end
  end

  // Link-domain datapath; mode bits are static while pins are driven
  always_comb begin
    rxp_d = '0;
    if (run_l) begin
      if (rmii_l) begin
        rxp_d.dv = i_phy_rx.crs | i_phy_rx.dv;
        if (rxp_d.dv) begin
          rxp_d.rxd = {2'b00, i_phy_rx.rxd[1:0]};
        end
        rxp_d.er = i_phy_rx.er;
      end else begin
        rxp_d.dv  = i_phy_rx.dv;
        rxp_d.rxd = i_phy_rx.dv ? i_phy_rx.rxd : 4'h0;
        rxp_d.er  = i_phy_rx.er;
        rxp_d.col = i_phy_rx.col;
        rxp_d.crs = i_phy_rx.crs;
      end
    end
    txv_d = run_l & i_transmit_enable_in;
    tx_d  = 4'h0;
    if (txv_d) begin
      tx_d = rmii_l ? {2'b00, i_txd[1:0]} : i_txd;
    end
    act_d = i_transmit_enable_in | i_phy_rx.dv;
  end

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rxp_q <= '0;
      tx_q  <= '0;
      txv_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      rxp_q <= rxp_d;
      tx_q  <= tx_d;
      txv_q <= txv_d;
      act_q <= act_d;
    end
  end

  always_comb begin
    o_pin_out.addr    = {rxp_q.rxd[1], rxp_q.rxd[2], rxp_q.rxd[3]};
    o_pin_out.duplex  = rxp_q.rxd[0];
    o_pin_out.iface   = {rxp_q.dv, rxp_q.crs, rxp_q.col};
    o_pin_out.detach  = rxp_q.er;
    o_pin_out.autoneg = first_indicator_out;
    o_pin_out.speed   = second_indicator_out;
    // inputs in the strap window, and all but the LED pins while CTRL_ISO is set
    o_pin_oe          = run && !ctrl_q[CTRL_ISO] ? '1 : '0;
    o_pin_oe.autoneg  = run;
    o_pin_oe.speed    = run;
  end

  assign o_station_number = {2'b00, strap_q.addr};
  assign o_mode           = mode;
  assign o_reg_rdata      = rdata_q;
  assign o_irq_out        = irq_q;
  assign o_tx_dat         = tx_q;
  assign o_tx_vld         = txv_q;
  assign o_mdio_out       = mdo_q;
  assign o_mdio_oe        = mdoe_q;
  assign o_mgmt_din       = din_q;
  assign o_mgmt_din_vld   = dinv_q;

  sequence s_release;
    state_q == ST_STRAP && rst_n_s ##1 state_q == ST_RUN;
  endsequence

  strap_oe_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_q == ST_STRAP |-> o_pin_oe == '0)
    else $error("strap pin driven during reset window");
  addr_upper_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    o_station_number[4:3] == 2'b00)
    else $error("station number upper bits not zero");
  strap_latch_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_release |-> strap_q == $past(pin_s))
    else $error("straps not captured at window end");
  ctrl_load_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_release |->
    ctrl_q[CTRL_DUP] == !$past(pin_s.duplex) && ctrl_q[CTRL_ISO] == $past(pin_s.detach))
    else $error("duplex or detach strap not loaded");
  speed_load_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    s_release |->
    ctrl_q[CTRL_SPEED] == $past(pin_s.speed) && ctrl_q[CTRL_ANEG] == $past(pin_s.autoneg))
    else $error("speed or autoneg strap not loaded");
  strap_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    state_q == ST_RUN ##1 state_q == ST_RUN |->
    $stable(strap_q))
    else $error("straps changed outside reset");
  window_len_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    $rose(rst_n_s) && state_q == ST_STRAP |->
    state_q == ST_STRAP [*8])
    else $error("strap window ended early");
  rmii_decode_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    strap_q.iface == IFACE_RMII |-> o_mode == MODE_RMII)
    else $error("interface code decoded wrongly");
  irq_pol_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ##1 o_irq_out ==
    ($past(pctl_q[PCTL_POL]) ? $past(i_irq_cond) : !$past(i_irq_cond)))
    else $error("interrupt polarity wrong");
  mdio_sample_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    mdc_s && !mdc_q |=> o_mgmt_din_vld &&
    o_mgmt_din == $past(mdio_s))
    else $error("management bit not sampled on clock rise");
  tx_ignore_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    !i_transmit_enable_in |=> !o_tx_vld && o_tx_dat == 4'h0)
    else $error("transmit data passed without enable");
  rmii_rx_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    run_l && rmii_l && i_phy_rx.dv |=> rxp_q.rxd[1:0] == $past(i_phy_rx.rxd[1:0]))
    else $error("RMII receive bits lost");
endmodule : psm_top

/* dv/psm_mac_model.sv */
/*
 MAC side of the link port: drives transmit enable and data.
 Assumes one bench process calls send and idle.
*/
`timescale 1ns/1ps
module psm_mac_model (
  input  wire logic       i_link_clk,
  output logic            o_transmit_enable_in,
  output logic [3:0]      o_txd
);
  logic [3:0] nib_q;
  logic [3:0] idle_q = 4'h5;

  initial begin
    o_transmit_enable_in = 1'b0;
    nib_q  = 4'h0;
  end
  // idle data keeps changing; one driver per signal avoids an edge race
  always @(posedge i_link_clk) begin
    idle_q <= ~idle_q;
  end
  assign o_txd = o_transmit_enable_in ? nib_q : idle_q;
  task automatic send(input logic [3:0] nib);
    @(posedge i_link_clk);
    o_transmit_enable_in <= 1'b1;
    nib_q  <= nib;
  endtask : send
  task automatic idle();
    @(posedge i_link_clk);
    o_transmit_enable_in <= 1'b0;
  endtask : idle
endmodule : psm_mac_model

/* dv/phy_strap_and_pin_function_mux_test.sv */
/*
 Self-checking bench for the strap and pin-function mux.
 Assumes psm_pkg and the MAC model; one management bit driven per strap set.
*/
`timescale 1ns/1ps
module phy_strap_and_pin_function_mux_test;
  import psm_pkg::*;
  logic        clk, lclk, rst, crst_n, wr, rd, link, irqc, pol, transmit_enable_in, tvld, irq;
  logic        mdc, mdio, mdo, mdoe, mdin, mvld, mout, moe;
  psm_strap_t  pin, pout, poe, st;
  psm_rxpin_t  rx;
  logic [3:0]  txd, tdat;
  logic [7:0]  addr;
  logic [15:0] wdat, rdat, v;
  logic [4:0]  stn;
  psm_mode_t   mode;
  int          seed, num_errors, n_tests;
  logic [2:0]  codes [4] = '{IFACE_MII, IFACE_RMII, IFACE_PRE, 3'h6};

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // link clock, slowed; the logic does not depend on its rate
  initial begin
    lclk = 1'b0;
    #7;
    forever #62.5 lclk = ~lclk;
  end

  psm_top #(.BLINK_CYC(8)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk), .i_chip_rst_n(crst_n),
    .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
    .i_transmit_enable_in(transmit_enable_in), .i_txd(txd), .i_phy_rx(rx),
    .o_tx_dat(tdat), .o_tx_vld(tvld), .i_link_up(link), .i_irq_cond(irqc),
    .o_irq_out(irq), .i_mdc(mdc), .i_mdio_in(mdio), .o_mdio_out(mout), .o_mdio_oe(moe),
    .i_mgmt_dout(mdo), .i_mgmt_doe(mdoe), .o_mgmt_din(mdin), .o_mgmt_din_vld(mvld),
    .i_reg_addr(addr), .i_reg_wdata(wdat), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdat), .o_station_number(stn), .o_mode(mode)
  );
  psm_mac_model i_mac (.i_link_clk(lclk), .o_transmit_enable_in(transmit_enable_in), .o_txd(txd));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdat;
  endtask : rreg

  // one management bit: sampled after the rise, driven after the fall
  task automatic mdio_bit(input logic b);
    @(posedge clk);
    mdio <= b;
    mdo  <= ~b;
    mdoe <= 1'b1;
    @(posedge clk);
    mdc <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("mgmt in", {14'h0, 1'b1, b}, {14'h0, mvld, mdin});
    @(posedge clk);
    mdc <= 1'b0;
    #1;
    chk("mgmt pulse", 16'h0, {15'h0, mvld});
    repeat (3) @(posedge clk);
    #1;
    chk("mgmt out", {14'h0, 1'b1, ~b}, {14'h0, moe, mout});
  endtask : mdio_bit

  function automatic logic [15:0] exp_ctrl(input psm_strap_t s);
    exp_ctrl = 16'h0;
    exp_ctrl[CTRL_SPEED] = s.speed;
    exp_ctrl[CTRL_ANEG] = s.autoneg;
    exp_ctrl[CTRL_ISO] = s.detach;
    exp_ctrl[CTRL_DUP] = !s.duplex;
  endfunction : exp_ctrl

  function automatic psm_mode_t exp_mode(input logic [2:0] c);
    case (c)
      IFACE_MII:  exp_mode = MODE_MII;
      IFACE_RMII: exp_mode = MODE_RMII;
      IFACE_PRE:  exp_mode = MODE_MII_PRE;
      default:    exp_mode = MODE_RSVD;
    endcase
  endfunction : exp_mode

  // Pins show the inverse first, so only levels late in the window count
  task automatic strap(input psm_strap_t s);
    @(posedge clk);
    crst_n <= 1'b0;
    pin    <= ~s;
    repeat (4) @(posedge clk);
    #1;
    chk("pin_oe window", 16'h0, {6'h0, poe});
    @(posedge clk);
    pin <= s;
    @(posedge clk);
    crst_n <= 1'b1;
    repeat (60) @(posedge clk);
  endtask : strap

  // RMII compares the low dibit only
  task automatic chk_link(input logic rmii, input logic en,
                          input logic [3:0] t, input logic [3:0] r);
    logic [3:0] m;
    m = rmii ? 4'h3 : 4'hf;
    chk("tx", {11'h0, en, t & m & {4{en}}}, {11'h0, tvld, tdat & m});
    chk("rx", {11'h0, en, r & m & {4{en}}},
        {11'h0, pout.iface[2], {pout.addr[0], pout.addr[1], pout.addr[2], pout.duplex} & m});
  endtask : chk_link

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    seed = 24;
    num_errors = 0;
    n_tests = 0;
    rst = 1'b1;
    crst_n = 1'b1;
    pin = STRAP_DFLT;
    rx = '0;
    {link, irqc, wr, rd, addr, wdat, mdc, mdio, mdo, mdoe} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      st = v[9:0];
      if (i == 0) st = STRAP_DFLT;
      else if (i < 4) begin
        st.iface = codes[i];
        st.detach = 1'b0;
      end
      if (i == 1) st.addr = 3'h7;
      strap(st);
      chk("station", {13'h0, st.addr}, {11'h0, stn});
      chk("mode", {14'h0, exp_mode(st.iface)}, {14'h0, mode});
      rreg(REG_CTRL, v);
      chk("ctrl", exp_ctrl(st), v & 16'h3500);
      rreg(REG_ADV, v);
      chk("adv", {7'h0, st.speed ? ADV_CAP_100 : ADV_CAP_10, 5'h0}, v & 16'h01e0);
      chk("pin_oe run", st.detach ? 16'h0300 : 16'h03ff, {6'h0, poe});
      mdio_bit(1'($random(seed)));
      @(posedge clk);
      pin  <= ~st;
      link <= $random(seed);
      irqc <= $random(seed);
      pol = $random(seed);
      wreg(REG_PCTL, {1'b0, i[0], 4'h0, pol, 9'h0});
      repeat (6) @(posedge clk);
      #1;
      chk("station hold", {13'h0, st.addr}, {11'h0, stn});
      chk("irq", {15'h0, pol ? irqc : !irqc}, {15'h0, irq});
      chk("led", {14'h0, !link, i[0] ? 1'b1 : !st.speed},
          {14'h0, pout.autoneg, pout.speed});
      if (!st.detach && exp_mode(st.iface) != MODE_RSVD) begin
        for (int k = 0; k < 3; k++) begin
          v = 16'($random(seed));
          i_mac.send(v[3:0]);
          rx <= '{rxd: v[7:4], dv: 1'b1, default: 1'b0};
          @(posedge lclk);
          #1;
          chk_link(st.iface == IFACE_RMII, 1'b1, v[3:0], v[7:4]);
        end
        i_mac.idle();
        rx <= '{rxd: v[11:8], dv: 1'b0, default: 1'b0};
        @(posedge lclk);
        #1;
        chk_link(st.iface == IFACE_RMII, 1'b0, v[3:0], v[11:8]);
      end
      $display("Strap set %0d finished", i);
    end
    rreg(8'h10, v);
    chk("unmapped", 16'h0, v);
    wreg(REG_STRAP, 16'hffff);
    rreg(REG_STRAP, v);
    chk("strap status", {8'h0, st.iface, 2'b00, st.addr}, v);
    $display("Register access finished");
    complete_run();
  end
endmodule : phy_strap_and_pin_function_mux_test
